// >>> verilog/xsd_pkg.sv
// constants and types for the extended stack instruction decoder
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package xsd_pkg;

  // ----------------------------------------------------------------
  // opcodes and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] XSD_OP_MOVE = 8'heb;
  localparam logic [3:0] XSD_OP_MOVE_DEST = 4'hf;
  localparam logic [7:0] XSD_OP_PUSH = 8'hfa;
  localparam logic [7:0] XSD_OP_SUB = 8'he9;
  localparam int XSD_MOVE_FLAG_BIT = 7;
  localparam logic [1:0] XSD_SEL_RETURN = 2'h3;
  localparam logic [1:0] XSD_SEL_STACK = 2'h2;

  // ----------------------------------------------------------------
  // data space map
  // ----------------------------------------------------------------
  localparam logic [7:0] XSD_INDEX_LIMIT = 8'h5f;
  localparam logic [11:0] XSD_ACCESS_HIGH_BASE = 12'hf00;
  localparam logic [11:0] XSD_IND0_BASE = 12'hfeb;
  localparam logic [11:0] XSD_IND1_BASE = 12'hfe3;
  localparam logic [11:0] XSD_IND2_BASE = 12'hfdb;
  localparam logic [11:0] XSD_IND_SPAN = 12'h005;

  // ----------------------------------------------------------------
  // register port offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] XSD_CTRL_OFF = 8'h00;
  localparam logic [7:0] XSD_PTR_BASE_OFF = 8'h04;
  localparam logic [7:0] XSD_PTR_STEP = 8'h04;
  localparam logic [7:0] XSD_STATUS_OFF = 8'h10;
  localparam logic [11:0] XSD_PTR_RESET = 12'h000;
  localparam logic XSD_EXT_RESET = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MOVE_DEST,
    ST_MOVE_WRITE,
    ST_RET_NOP
  } xsd_state_type;

endpackage

// >>> verilog/xsd_operand_map.sv
// maps a standard byte or bit instruction operand to a data address
`timescale 1ns/1ns
module xsd_operand_map (
  input wire logic extEnable,
  input wire logic accessBit,
  input wire logic [7:0] operand,
  input wire logic [3:0] bankSelect,
  input wire logic [11:0] stackPointer,
  output logic [11:0] dataAddr
);

  // ----------------------------------------------------------------
  // operand classification
  // ----------------------------------------------------------------
  wire logic lowHalf = (operand <= xsd_pkg::XSD_INDEX_LIMIT);
  wire logic indexed = extEnable && !accessBit && lowHalf;
  // the sum drops its carry so the address wraps inside the data space
  wire logic [11:0] indexSum = 12'(stackPointer + {4'h0, operand});
  wire logic [11:0] accessAddr = lowHalf ? {4'h0, operand}
                                         : (xsd_pkg::XSD_ACCESS_HIGH_BASE | {4'h0, operand});

  // indexed first, then banked, then the split access bank
  assign dataAddr = indexed ? indexSum
                  : accessBit ? {bankSelect, operand}
                  : accessAddr;

endmodule

// >>> verilog/xsd_decode.sv
// extended stack instruction decode and execute core
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module xsd_decode (
  input wire logic sys_clk,
  input wire logic arst_n,
  // instruction words from the fetch pipeline
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  output logic instrReady,
  // data memory port, read data one cycle after the read strobe
  output logic [11:0] memAddr,
  output logic [7:0] memWrData,
  output logic memWe,
  output logic memRe,
  input wire logic [7:0] memRdData,
  // return path
  input wire logic [20:0] returnStackTop,
  output logic pcLoad,
  output logic [20:0] pcValue,
  // standard byte and bit instruction operand resolution
  input wire logic stdValid,
  input wire logic [7:0] stdOperand,
  input wire logic stdAccess,
  input wire logic stdDest,
  input wire logic [3:0] bankSelect,
  output logic stdAddrValid,
  output logic [11:0] stdAddr,
  output logic stdToFile,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData
);

  xsd_pkg::xsd_state_type state;
  xsd_pkg::xsd_state_type next_state;
  logic extEnable;
  logic [11:0] ptr [3];
  logic [11:0] nextPtr [3];
  logic [11:0] destAddr;
  logic srcIndirect;
  logic destIndirect;
  logic rdTaken;
  logic [7:0] srcByte;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  function automatic logic isIndirect(input logic [11:0] addr);
    isIndirect = (12'(addr - xsd_pkg::XSD_IND0_BASE) < xsd_pkg::XSD_IND_SPAN)
              || (12'(addr - xsd_pkg::XSD_IND1_BASE) < xsd_pkg::XSD_IND_SPAN)
              || (12'(addr - xsd_pkg::XSD_IND2_BASE) < xsd_pkg::XSD_IND_SPAN);
  endfunction

  wire logic [11:0] sp = ptr[2];
  wire logic [7:0] opHi = instrWord[15:8];
  wire logic take = instrValid && instrReady && (state == xsd_pkg::ST_IDLE);
  // extended opcodes only exist while the extension is on
  wire logic isMove = take && extEnable && (opHi == xsd_pkg::XSD_OP_MOVE)
                      && instrWord[xsd_pkg::XSD_MOVE_FLAG_BIT];
  wire logic isPush = take && extEnable && (opHi == xsd_pkg::XSD_OP_PUSH);
  wire logic isSub = take && extEnable && (opHi == xsd_pkg::XSD_OP_SUB);
  wire logic [1:0] subSel = instrWord[7:6];
  wire logic [5:0] subK = instrWord[5:0];
  wire logic isRet = isSub && (subSel == xsd_pkg::XSD_SEL_RETURN);
  wire logic destTake = instrValid && (state == xsd_pkg::ST_MOVE_DEST);
  wire logic destOk = destTake && (instrWord[15:12] == xsd_pkg::XSD_OP_MOVE_DEST);
  // both offsets ride on the stack pointer and wrap in 12 bits
  wire logic [11:0] srcSum = 12'(sp + {5'h00, instrWord[6:0]});
  wire logic [11:0] destSum = 12'(sp + {5'h00, instrWord[6:0]});

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // the move waits for its second word; the return burns one idle cycle
  always_comb begin
    next_state = state;
    unique case (state)
      xsd_pkg::ST_IDLE: begin
        if (isMove) begin
          next_state = xsd_pkg::ST_MOVE_DEST;
        end else if (isRet) begin
          next_state = xsd_pkg::ST_RET_NOP;
        end
      end
      xsd_pkg::ST_MOVE_DEST: begin
        if (destOk) begin
          next_state = xsd_pkg::ST_MOVE_WRITE;
        end else if (destTake) begin
          next_state = xsd_pkg::ST_IDLE; // a malformed second word drops the move
        end
      end
      xsd_pkg::ST_MOVE_WRITE: next_state = xsd_pkg::ST_IDLE;
      xsd_pkg::ST_RET_NOP: next_state = xsd_pkg::ST_IDLE;
    endcase
  end

  wire logic next_ready = (next_state == xsd_pkg::ST_IDLE)
                       || (next_state == xsd_pkg::ST_MOVE_DEST);

  // state and handshake
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= xsd_pkg::ST_IDLE;
      instrReady <= 1'b0;
    end else begin
      state <= next_state;
      instrReady <= next_ready;
    end
  end

  // move bookkeeping between its two words; the read data stand one cycle
  // only, so they are held in case the second word arrives late
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      destAddr <= 12'h000;
      srcIndirect <= 1'b0;
      destIndirect <= 1'b0;
      rdTaken <= 1'b0;
      srcByte <= 8'h00;
    end else begin
      rdTaken <= memRe;
      if (rdTaken) begin
        srcByte <= memRdData;
      end
      if (isMove) begin
        srcIndirect <= isIndirect(srcSum);
      end
      if (destOk) begin
        destAddr <= destSum;
        destIndirect <= isIndirect(destSum);
      end
    end
  end

  // ----------------------------------------------------------------
  // pointer registers
  // ----------------------------------------------------------------
  // only pointers change here; no flag is ever written by this block
  for (genvar g = 0; g < 3; g++) begin : gPtr
    wire logic subHit = isSub && ((subSel == 2'(g))
                        || (g == 2 && subSel == xsd_pkg::XSD_SEL_RETURN));
    wire logic pushHit = (g == 2) && isPush;
    wire logic busHit = regWrite && (regAddr == 8'(xsd_pkg::XSD_PTR_BASE_OFF
                        + 8'(g) * xsd_pkg::XSD_PTR_STEP));
    // instruction updates win over a software write in the same cycle
    assign nextPtr[g] = subHit ? 12'(ptr[g] - {6'h00, subK})
                      : pushHit ? 12'(ptr[g] - 12'h001)
                      : busHit ? regWrData[11:0]
                      : ptr[g];
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        ptr[g] <= xsd_pkg::XSD_PTR_RESET;
      end else begin
        ptr[g] <= nextPtr[g];
      end
    end
  end

  // ----------------------------------------------------------------
  // data memory port
  // ----------------------------------------------------------------
  // a destination of program counter low or return stack top is not
  // guarded; software must not aim a move there
  wire logic next_memWe = isPush
                       || (state == xsd_pkg::ST_MOVE_WRITE && !destIndirect);
  wire logic [11:0] next_memAddr = isPush ? sp
                                 : isMove ? srcSum
                                 : destAddr;
  wire logic [7:0] srcData = rdTaken ? memRdData : srcByte;
  wire logic [7:0] next_memWrData = isPush ? instrWord[7:0]
                                  : srcIndirect ? 8'h00
                                  : srcData;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      memAddr <= 12'h000;
      memWrData <= 8'h00;
      memWe <= 1'b0;
      memRe <= 1'b0;
    end else begin
      memAddr <= next_memAddr;
      memWrData <= next_memWrData;
      memWe <= next_memWe;
      memRe <= isMove;
    end
  end

  // return loads the pc straight from the return stack top
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pcLoad <= 1'b0;
      pcValue <= 21'h00000;
    end else begin
      pcLoad <= isRet;
      pcValue <= isRet ? returnStackTop : pcValue;
    end
  end

  // ----------------------------------------------------------------
  // standard operand resolution
  // ----------------------------------------------------------------
  logic [11:0] mappedAddr;

  xsd_operand_map uMap (
    .extEnable(extEnable),
    .accessBit(stdAccess),
    .operand(stdOperand),
    .bankSelect(bankSelect),
    .stackPointer(sp),
    .dataAddr(mappedAddr)
  );

  // the destination bit passes through untouched in every mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stdAddrValid <= 1'b0;
      stdAddr <= 12'h000;
      stdToFile <= 1'b0;
    end else begin
      stdAddrValid <= stdValid;
      stdAddr <= stdValid ? mappedAddr : stdAddr;
      stdToFile <= stdValid ? stdDest : stdToFile;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  wire logic ctrlHit = regAddr == xsd_pkg::XSD_CTRL_OFF;
  wire logic [7:0] ptrIdx = 8'(regAddr - xsd_pkg::XSD_PTR_BASE_OFF) >> 2;
  wire logic ptrHit = (regAddr[1:0] == 2'h0) && (regAddr >= xsd_pkg::XSD_PTR_BASE_OFF)
                   && (ptrIdx < 8'h03);
  wire logic [31:0] next_rdData = ctrlHit ? {31'h0, extEnable}
      : ptrHit ? {20'h00000, ptr[ptrIdx[1:0]]}
      : (regAddr == xsd_pkg::XSD_STATUS_OFF) ? {30'h0, state}
      : 32'h00000000;

  // enable resets off so legacy code addresses plainly
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      extEnable <= xsd_pkg::XSD_EXT_RESET;
      regRdData <= 32'h00000000;
    end else begin
      if (regWrite && ctrlHit) begin
        extEnable <= regWrData[0];
      end
      regRdData <= regRead ? next_rdData : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence retPulse;
    pcLoad && !instrReady && (state == xsd_pkg::ST_RET_NOP);
  endsequence
  sequence retDone;
    !pcLoad && instrReady && (state == xsd_pkg::ST_IDLE);
  endsequence

  push_write_a: assert property (isPush |=> memWe && memAddr == $past(sp)
      && memWrData == $past(instrWord[7:0]))
    else $error("push literal not written at stack pointer");
  push_dec_a: assert property (isPush |=> ptr[2] == 12'($past(ptr[2]) - 12'h001))
    else $error("push did not decrement stack pointer");
  sub_ptr_a: assert property (isSub && subSel == 2'h0
      |=> ptr[0] == 12'($past(ptr[0]) - {6'h00, $past(subK)}))
    else $error("pointer subtract wrong");
  sub_ret_a: assert property (isRet |=> retPulse ##1 retDone)
    else $error("subtract and return sequence wrong");
  ret_sp_a: assert property (isRet
      |=> ptr[2] == 12'($past(ptr[2]) - {6'h00, $past(subK)}) && ptr[1] == $past(ptr[1]))
    else $error("return variant touched wrong pointer");
  move_src_a: assert property (isMove |=> memRe && memAddr == $past(srcSum))
    else $error("move source address wrong");
  move_nop_a: assert property (state == xsd_pkg::ST_MOVE_WRITE && destIndirect
      |=> !memWe)
    else $error("move wrote to indirect destination");
  move_zero_a: assert property (state == xsd_pkg::ST_MOVE_WRITE && srcIndirect && !destIndirect
      |=> memWe && memWrData == 8'h00 && memAddr == $past(destAddr))
    else $error("indirect source did not give zero");
  std_index_a: assert property (stdValid && extEnable && !stdAccess
      && stdOperand <= xsd_pkg::XSD_INDEX_LIMIT
      |=> stdAddr == 12'($past(sp) + {4'h0, $past(stdOperand)}))
    else $error("indexed operand not offset from stack pointer");
  std_bank_a: assert property (stdValid && !extEnable && stdAccess
      |=> stdAddr == {$past(bankSelect), $past(stdOperand)})
    else $error("banked operand address wrong");
  fuse_off_a: assert property (!extEnable && state == xsd_pkg::ST_IDLE |=> !memWe && !pcLoad)
    else $error("extended instruction ran with extension off");
  std_high_a: assert property (stdValid && !stdAccess && stdOperand > xsd_pkg::XSD_INDEX_LIMIT
      |=> stdAddr == (xsd_pkg::XSD_ACCESS_HIGH_BASE | {4'h0, $past(stdOperand)}))
    else $error("upper access bank operand address wrong");
  std_dest_a: assert property (stdValid |=> stdAddrValid && stdToFile == $past(stdDest))
    else $error("destination select bit not passed through");
  sub_one_a: assert property (isSub && subSel == 2'h1
      |=> ptr[1] == 12'($past(ptr[1]) - {6'h00, $past(subK)}))
    else $error("pointer one subtract wrong");
  move_data_a: assert property (state == xsd_pkg::ST_MOVE_WRITE && !srcIndirect && !destIndirect
      |=> memWe && memWrData == srcByte)
    else $error("moved byte differs from the byte read");

endmodule

// >>> verif/xsd_mem_model.sv
// data memory model on the far side of the extended stack instruction decoder
`timescale 1ns/1ns
module xsd_mem_model (
  input wire logic sys_clk,
  input wire logic [11:0] memAddr,
  input wire logic [7:0] memWrData,
  input wire logic memWe,
  input wire logic memRe,
  output logic [7:0] memRdData
);
  // ----------------------------------------
  // storage and registered read
  // ----------------------------------------
  logic [7:0] mem [0:4095];
  logic [7:0] rdByte;
  logic rdLive;
  initial begin
    for (int a = 0; a < 4096; a++)
      mem[a] = 8'h00;
    rdByte = 8'h00;
    rdLive = 1'b0;
  end
  // any of the 4096 bytes can be written or read
  always @(posedge sys_clk) begin
    if (memWe)
      mem[memAddr] <= memWrData;
    rdLive <= memRe;
    rdByte <= mem[memAddr];
  end
  // read data stand one cycle only; else inverted so a late sample shows up
  assign memRdData = rdLive ? rdByte : ~rdByte;
endmodule

// >>> verif/test_extended_stack_instr_decode.sv
// self-checking bench for the extended stack instruction decoder
`timescale 1ns/1ns
module test_extended_stack_instr_decode;
  logic sys_clk, arst_n, instrValid, instrReady, memWe, memRe, pcLoad, rdPend, extOn;
  logic stdValid, stdAccess, stdDest, stdAddrValid, stdToFile, regWrite, regRead;
  logic [15:0] instrWord;
  logic [11:0] memAddr, stdAddr, sp;
  logic [7:0] memWrData, memRdData, stdOperand, regAddr;
  logic [20:0] returnStackTop, pcValue;
  logic [3:0] bankSelect;
  logic [31:0] regWrData, regRdData, r;
  logic [19:0] memQ[$];
  logic [11:0] srcQ[$];
  logic [20:0] pcQ[$];
  logic [12:0] stdQ[$];
  logic [31:0] regQ[$];
  int n_mismatch, comparisons, cycles, seed, i;

  xsd_decode xsd_decode_inst (.sys_clk(sys_clk), .arst_n(arst_n), .instrValid(instrValid),
    .instrWord(instrWord), .instrReady(instrReady), .memAddr(memAddr), .memWrData(memWrData),
    .memWe(memWe), .memRe(memRe), .memRdData(memRdData), .returnStackTop(returnStackTop),
    .pcLoad(pcLoad), .pcValue(pcValue), .stdValid(stdValid), .stdOperand(stdOperand),
    .stdAccess(stdAccess), .stdDest(stdDest), .bankSelect(bankSelect),
    .stdAddrValid(stdAddrValid), .stdAddr(stdAddr), .stdToFile(stdToFile), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
  xsd_mem_model xsd_mem_model_inst (.sys_clk(sys_clk), .memAddr(memAddr),
    .memWrData(memWrData), .memWe(memWe), .memRe(memRe), .memRdData(memRdData));

  // ----------------------------------------
  // clock, timeout and closing
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic complete_run;
    if (memQ.size() + pcQ.size() + stdQ.size() + regQ.size() + srcQ.size() != 0) begin
      n_mismatch++;
      $display("mismatch pending results expected 0 seen %0d",
        memQ.size() + pcQ.size() + stdQ.size() + regQ.size() + srcQ.size());
    end
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ceiling well above the fewer than 200 cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ----------------------------------------
  // compare and monitor
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // outputs are sampled before this edge's updates land
  always @(posedge sys_clk) begin
    if (memWe === 1'b1) begin
      if (memQ.size() == 0)
        check("memWe", 0, 1);
      else
        check("mem write", 32'(memQ.pop_front()), {memAddr, memWrData});
    end
    if (memRe === 1'b1) begin
      if (srcQ.size() == 0)
        check("memRe", 0, 1);
      else
        check("memRe addr", 32'(srcQ.pop_front()), 32'(memAddr));
    end
    if (pcLoad === 1'b1) begin
      if (pcQ.size() == 0)
        check("pcLoad", 0, 1);
      else
        check("pcValue", 32'(pcQ.pop_front()), 32'(pcValue));
    end
    if (stdAddrValid === 1'b1) begin
      if (stdQ.size() == 0)
        check("stdAddrValid", 0, 1);
      else
        check("stdAddr", 32'(stdQ.pop_front()), {stdToFile, stdAddr});
    end
    if (rdPend)
      check("regRdData", regQ.size() ? regQ.pop_front() : 0, regRdData);
    rdPend <= regRead;
  end

  // ----------------------------------------
  // drivers: each starts and ends just after an edge
  // ----------------------------------------
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic regRd(input logic [7:0] a, input logic [31:0] e);
    regQ.push_back(e);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic setSp(input logic [11:0] v);
    regWr(8'h0c, {20'h0, v});
    sp = v;
  endtask
  function automatic logic [11:0] mapOp(input logic a, input logic [7:0] o, input logic [3:0] b);
    if (a)
      return {b, o};
    if (extOn && o <= xsd_pkg::XSD_INDEX_LIMIT)
      return sp + {4'h0, o};
    if (o <= xsd_pkg::XSD_INDEX_LIMIT)
      return {4'h0, o};
    return xsd_pkg::XSD_ACCESS_HIGH_BASE | {4'h0, o};
  endfunction
  task automatic stdReq(input logic a, input logic [7:0] o, input logic d, input logic [3:0] b);
    stdQ.push_back({d, mapOp(a, o, b)});
    stdValid <= 1'b1;
    stdAccess <= a;
    stdOperand <= o;
    stdDest <= d;
    bankSelect <= b;
    @(posedge sys_clk);
    stdValid <= 1'b0;
    @(posedge sys_clk);
  endtask
  // holds the word until an edge where ready was high; caller lowers valid
  task automatic sendInstr(input logic [15:0] w);
    instrValid <= 1'b1;
    instrWord <= w;
    for (int j = 0; j < 20; j++) begin
      @(posedge sys_clk);
      if (instrReady === 1'b1)
        break;
    end
  endtask
  task automatic endInstr;
    instrValid <= 1'b0;
    @(posedge sys_clk);
  endtask
  // unused word2 bits are set to show they are ignored
  task automatic moveOp(input logic [6:0] s, input logic [6:0] d, input logic [7:0] pre,
      input logic [7:0] data, input logic doWrite);
    xsd_mem_model_inst.mem[sp + {5'h0, s}] = pre;
    srcQ.push_back(sp + {5'h0, s});
    if (doWrite)
      memQ.push_back({sp + {5'h0, d}, data});
    sendInstr({xsd_pkg::XSD_OP_MOVE, 1'b1, s});
    sendInstr({xsd_pkg::XSD_OP_MOVE_DEST, 5'h1f, d});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {arst_n, instrValid, stdValid, stdAccess, stdDest, regWrite, regRead, rdPend} = 8'h00;
    {instrWord, stdOperand, regAddr, bankSelect, regWrData, returnStackTop} = 89'h0;
    {extOn, sp, seed} = {1'b0, 12'h000, 32'(88252)};
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    regRd(8'h00, 32'h0);
    for (i = 0; i < 3; i++)
      regRd(8'h04 + 8'(i * 4), 32'h0);
    regRd(8'h20, 32'h0);
    regRd(8'h10, 32'h0);
    sendInstr({xsd_pkg::XSD_OP_PUSH, 8'h55});
    endInstr();
    regRd(8'h0c, 32'h0);
    stdReq(1'b0, 8'h20, 1'b1, 4'h3);
    stdReq(1'b0, 8'h80, 1'b0, 4'h3);
    stdReq(1'b1, 8'h12, 1'b1, 4'ha);
    $display("test extension off done");
    regWr(8'h00, 32'h1);
    extOn = 1'b1;
    setSp(12'h000);
    stdReq(1'b0, 8'h10, 1'b0, 4'h5);
    for (i = 0; i < 24; i++) begin
      r = $random(seed);
      if (i % 8 == 0)
        setSp(r[27:16]);
      stdReq(r[8], (i < 2) ? 8'h5f + 8'(i) : r[7:0], r[9], r[13:10]);
    end
    $display("test operand mapping done");
    setSp(12'h000);
    r = $random(seed);
    memQ.push_back({12'h000, r[7:0]});
    sendInstr({xsd_pkg::XSD_OP_PUSH, r[7:0]});
    memQ.push_back({12'hfff, r[15:8]});
    sendInstr({xsd_pkg::XSD_OP_PUSH, r[15:8]});
    endInstr();
    regRd(8'h0c, 32'hffe);
    $display("test push done");
    setSp(12'h080);
    moveOp(7'h05, 7'h06, 8'h33, 8'h33, 1'b1);
    endInstr();
    setSp(12'hfe0);
    moveOp(7'h0b, 7'h7f, 8'h5a, 8'h00, 1'b1);
    moveOp(7'h00, 7'h03, 8'h77, 8'h00, 1'b0);
    endInstr();
    setSp(12'hff0);
    moveOp(7'h7f, 7'h10, r[23:16], r[23:16], 1'b1);
    endInstr();
    $display("test indexed move done");
    for (i = 0; i < 3; i++) begin
      r = $random(seed);
      if (i == 0)
        r[11:0] = 12'h000;
      regWr(8'h04 + 8'(i * 4), {20'h0, r[11:0]});
      sendInstr({xsd_pkg::XSD_OP_SUB, 2'(i), r[17:12]});
      endInstr();
      regRd(8'h04 + 8'(i * 4), {20'h0, r[11:0] - {6'h0, r[17:12]}});
    end
    setSp(12'h010);
    r = $random(seed);
    returnStackTop <= r[20:0];
    pcQ.push_back(r[20:0]);
    sendInstr({xsd_pkg::XSD_OP_SUB, xsd_pkg::XSD_SEL_RETURN, 6'h3f});
    endInstr();
    check("instrReady", 32'h0, {31'h0, instrReady});
    regRd(8'h0c, 32'hfd1);
    $display("test subtract done");
    repeat (4) @(posedge sys_clk);
    complete_run();
  end
endmodule
